//--- rtl/suv_nvm.sv
// one-time-programmable byte store, registered read
`timescale 1ns/100ps
`include "suv_regs.svh"
module suv_nvm #(
	parameter int DEPTH = `SUV_NVM_BYTES
) (
	input wire logic clk,
	suv_nvm_if.mem bus
);
	// non-volatile cells: no reset, power cycle keeps them
	// unprogrammed cells read zero
	logic [7:0] cell_r [DEPTH] = '{default: 8'h00};
	always_ff @(posedge clk) begin
		if (bus.wr && (int'(bus.waddr) < DEPTH)) begin
			cell_r[bus.waddr] <= cell_r[bus.waddr] | bus.wdata;
		end
	end
	always_ff @(posedge clk) begin
		bus.rdata <= (int'(bus.addr) < DEPTH) ? cell_r[bus.addr] : 8'h00;
	end
endmodule

//--- rtl/suv_nvm_if.sv
// carrier between supervisor and parameter store
`timescale 1ns/100ps
interface suv_nvm_if;
	logic [3:0] addr;
	logic [7:0] rdata;
	logic wr;
	logic [3:0] waddr;
	logic [7:0] wdata;
	modport ctrl (output addr, output wr, output waddr, output wdata, input rdata);
	modport mem (input addr, input wr, input waddr, input wdata, output rdata);
endinterface

//--- rtl/suv_pkg.sv
// types of the supply supervisor
package suv_pkg;
	typedef enum logic [6:0] {
		SUV_RUN = 7'h01,
		SUV_SOFT_STOP = 7'h02,
		SUV_STOPPED_LOW = 7'h04,
		SUV_HARD_STOP = 7'h08,
		SUV_AUTARKIC = 7'h10,
		SUV_SHUTDOWN = 7'h20,
		SUV_IDLE = 7'h40
	} suv_state_t;
endpackage

//--- rtl/suv_regs.svh
// constants for the supply supervisor and parameter store
`ifndef SUV_REGS_SVH
`define SUV_REGS_SVH
// ----------------------------------------
// store byte offsets
// ----------------------------------------
`define SUV_THERMAL_CURRENT_CALIBRATION 4'h0
`define SUV_BAUD_BANDGAP_CALIBRATION 4'h1
`define SUV_THRESHOLD_AND_ADDRESS 4'h2
`define SUV_RUN_HOLD_CURRENT 4'h3
`define SUV_VELOCITY_LIMITS 4'h4
`define SUV_SECURE_HIGH_DIRECTION_ACCEL 4'h5
`define SUV_SECURE_LOW_FAILSAFE_SLEEP 4'h6
`define SUV_SUPPLY_THRESHOLD_STEPMODE_LOCKS 4'h7
`define SUV_ALT_SECURE_HIGH_OSCILLATOR 4'h8
`define SUV_ALT_SECURE_LOW_FAILSAFE_SLEEP 4'h9
`define SUV_NVM_BYTES 10
// ----------------------------------------
// field positions
// ----------------------------------------
`define SUV_ALT_SECURE_BIT 7
`define SUV_RISE_DEB_BIT 7
`define SUV_WARN_LVL_LSB 4
`define SUV_FACTORY_LOCK_BIT 1
`define SUV_GLOBAL_LOCK_BIT 0
`define SUV_FACTORY_MASK_0 8'h7f
`define SUV_FACTORY_MASK_1 8'h3f
`define SUV_FACTORY_MASK_8 8'h1f
// ----------------------------------------
// timing
// ----------------------------------------
`define SUV_CLK_MHZ 125
`define SUV_FALL_DEB_US 32
`define SUV_RISE_DEB_US 96
`define SUV_RISE_DEB_LONG_US 256
`define SUV_AUTARKIC_S 15
`define SUV_FALL_DEB_CYC (`SUV_FALL_DEB_US * `SUV_CLK_MHZ)
`define SUV_RISE_DEB_CYC (`SUV_RISE_DEB_US * `SUV_CLK_MHZ)
`define SUV_RISE_DEB_LONG_CYC (`SUV_RISE_DEB_LONG_US * `SUV_CLK_MHZ)
`define SUV_AUTARKIC_CYC (`SUV_AUTARKIC_S * 1000000 * `SUV_CLK_MHZ)
`endif

//--- rtl/suv_supervisor.sv
// supply undervoltage supervisor with parameter store control
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/100ps
`include "suv_regs.svh"
module suv_supervisor #(
	parameter int FALL_CYC = `SUV_FALL_DEB_CYC,
	parameter int RISE_CYC = `SUV_RISE_DEB_CYC,
	parameter int RISE_LONG_CYC = `SUV_RISE_DEB_LONG_CYC,
	parameter int AUT_CYC = `SUV_AUTARKIC_CYC,
	parameter int POS_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic warn_cmp_low,
	input wire logic severe_cmp_low,
	input wire logic resume_cmp_high,
	input wire logic moving,
	input wire logic stabilizing,
	input wire logic motion_done,
	input wire logic [POS_W-1:0] actual_position,
	input wire logic query_hdr,
	input wire logic target_upd,
	input wire logic [POS_W-1:0] target_upd_val,
	input wire logic dual_target_req,
	input wire logic nvm_prog,
	input wire logic [3:0] nvm_addr,
	input wire logic [7:0] nvm_data,
	input wire logic nvm_rd,
	output logic [7:0] nvm_rdata,
	output logic nvm_rvalid,
	output logic nvm_prog_ack,
	output logic warn_flag,
	output logic severe_flag,
	output logic steploss_flag,
	output logic soft_stop,
	output logic hard_stop,
	output logic bridge_hiz,
	output logic hold_current,
	output logic resume_motion,
	output logic dual_target_go,
	output logic [POS_W-1:0] target_position,
	output logic [2:0] warn_level_select,
	output logic [10:0] secure_position,
	output logic failsafe_en,
	output logic sleep_allow,
	output suv_pkg::suv_state_t state
);
	import suv_pkg::*;
	suv_nvm_if nb();
	suv_nvm #(.DEPTH(`SUV_NVM_BYTES)) u_nvm (.clk(clk), .bus(nb));

	function automatic logic [7:0] prot_mask(input logic [3:0] a, input logic fl);
		logic [7:0] m;
		m = 8'h00;
		if (fl) begin
			case (a)
				4'h0: m = `SUV_FACTORY_MASK_0;
				4'h1: m = `SUV_FACTORY_MASK_1;
				4'h8: m = `SUV_FACTORY_MASK_8;
				default: m = 8'h00;
			endcase
		end
		return m;
	endfunction

	// ----------------------------------------
	// power-up load of the parameter store
	// ----------------------------------------
	// bytes latched only at reset release, so new zaps wait for the next reset
	logic [3:0] ld_idx_r;
	logic ld_busy_r, ld_pend_r;
	logic [7:0] b5_r, b6_r, b7_r, b8_r, b9_r;
	logic alt_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			ld_idx_r <= 4'h0;
			ld_busy_r <= 1'b1;
			ld_pend_r <= 1'b0;
		end else if (ld_busy_r) begin
			ld_pend_r <= 1'b1;
			if (ld_idx_r == 4'h9) begin
				ld_busy_r <= 1'b0;
			end else begin
				ld_idx_r <= ld_idx_r + 4'h1;
			end
		end else begin
			ld_pend_r <= 1'b0;
		end
	end
	logic [3:0] ld_cap_r;
	always_ff @(posedge clk) begin
		ld_cap_r <= ld_idx_r;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			b5_r <= 8'h00;
			b6_r <= 8'h00;
			b7_r <= 8'h00;
			b8_r <= 8'h00;
			b9_r <= 8'h00;
			alt_r <= 1'b0;
		end else if (ld_pend_r) begin
			case (ld_cap_r)
				4'h0: alt_r <= nb.rdata[`SUV_ALT_SECURE_BIT];
				4'h5: b5_r <= nb.rdata;
				4'h6: b6_r <= nb.rdata;
				4'h7: b7_r <= nb.rdata;
				4'h8: b8_r <= nb.rdata;
				4'h9: b9_r <= nb.rdata;
				default: ;
			endcase
		end
	end
	// live lock state, read by the programming path
	logic flock_r, glock_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			flock_r <= 1'b0;
			glock_r <= 1'b0;
		end else if (nb.wr && nb.waddr == `SUV_SUPPLY_THRESHOLD_STEPMODE_LOCKS) begin
			flock_r <= flock_r | nb.wdata[`SUV_FACTORY_LOCK_BIT];
			glock_r <= glock_r | nb.wdata[`SUV_GLOBAL_LOCK_BIT];
		end else if (ld_pend_r && ld_cap_r == `SUV_SUPPLY_THRESHOLD_STEPMODE_LOCKS) begin
			flock_r <= nb.rdata[`SUV_FACTORY_LOCK_BIT];
			glock_r <= nb.rdata[`SUV_GLOBAL_LOCK_BIT];
		end
	end

	// ----------------------------------------
	// programming and readback
	// ----------------------------------------
	logic rd_pend_r, rd_pend2_r;
	logic [3:0] rd_addr_r;
	// secure byte reads redirected to the alternate bytes when alt select is set
	function automatic logic [3:0] map_addr(input logic [3:0] a, input logic alt);
		logic [3:0] m;
		m = a;
		if (alt && a == `SUV_SECURE_HIGH_DIRECTION_ACCEL) begin
			m = `SUV_ALT_SECURE_HIGH_OSCILLATOR;
		end else if (alt && a == `SUV_SECURE_LOW_FAILSAFE_SLEEP) begin
			m = `SUV_ALT_SECURE_LOW_FAILSAFE_SLEEP;
		end
		return m;
	endfunction
	always_comb begin
		nb.addr = ld_busy_r ? ld_idx_r : rd_addr_r;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			nb.wr <= 1'b0;
			nb.waddr <= 4'h0;
			nb.wdata <= 8'h00;
			nvm_prog_ack <= 1'b0;
		end else begin
			nvm_prog_ack <= nvm_prog && !ld_busy_r;
			// global lock rejects all; factory lock masks its bits
			// only zeros get zapped; ones already set stay untouched
			nb.wr <= nvm_prog && !ld_busy_r && !glock_r;
			nb.waddr <= nvm_addr;
			nb.wdata <= nvm_data & ~prot_mask(nvm_addr, flock_r);
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_addr_r <= 4'h0;
			rd_pend_r <= 1'b0;
			rd_pend2_r <= 1'b0;
			nvm_rvalid <= 1'b0;
			nvm_rdata <= 8'h00;
		end else begin
			if (nvm_rd && !ld_busy_r) begin
				rd_addr_r <= map_addr(nvm_addr, alt_r);
			end
			rd_pend_r <= nvm_rd && !ld_busy_r;
			// store output is registered, so the byte stands one cycle after the address
			rd_pend2_r <= rd_pend_r;
			nvm_rvalid <= 1'b0;
			if (rd_pend2_r && !ld_busy_r) begin
				nvm_rvalid <= 1'b1;
				nvm_rdata <= nb.rdata;
			end
		end
	end

	// ----------------------------------------
	// active parameters
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			warn_level_select <= 3'h0;
			secure_position <= 11'h000;
			failsafe_en <= 1'b0;
			sleep_allow <= 1'b0;
		end else begin
			// resume and severe levels derive from this code in the comparators
			warn_level_select <= b7_r[`SUV_WARN_LVL_LSB +: 3];
			if (alt_r) begin
				secure_position <= {b8_r[7:5], b9_r[7:2], 2'b00};
				failsafe_en <= b9_r[1];
				sleep_allow <= b9_r[0];
			end else begin
				secure_position <= {b5_r[7:5], b6_r[7:2], 2'b00};
				failsafe_en <= b6_r[1];
				sleep_allow <= b6_r[0];
			end
		end
	end

	// ----------------------------------------
	// comparator debouncers
	// ----------------------------------------
	// asymmetric filter: quick to react on falls, slower on recovery
	logic [31:0] fall_cnt_r, rise_cnt_r;
	logic warn_low_r, resume_ok_r;
	int rise_lim;
	always_comb begin
		rise_lim = b7_r[`SUV_RISE_DEB_BIT] ? RISE_LONG_CYC : RISE_CYC;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			fall_cnt_r <= 32'h0;
			warn_low_r <= 1'b0;
		end else if (!warn_cmp_low) begin
			fall_cnt_r <= 32'h0;
			warn_low_r <= 1'b0;
		end else if (fall_cnt_r >= 32'(FALL_CYC - 1)) begin
			warn_low_r <= 1'b1;
		end else begin
			fall_cnt_r <= fall_cnt_r + 32'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			rise_cnt_r <= 32'h0;
			resume_ok_r <= 1'b0;
		end else if (!resume_cmp_high) begin
			rise_cnt_r <= 32'h0;
			resume_ok_r <= 1'b0;
		end else if (rise_cnt_r >= 32'(rise_lim - 1)) begin
			resume_ok_r <= 1'b1;
		end else begin
			rise_cnt_r <= rise_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// supply state machine
	// ----------------------------------------
	// working state cleared by core reset; autarkic runs while it is absent
	suv_state_t state_nxt;
	logic [31:0] aut_cnt_r;
	logic aut_expired;
	assign aut_expired = (aut_cnt_r >= 32'(AUT_CYC - 1));
	always_comb begin
		state_nxt = state;
		case (state)
			SUV_IDLE, SUV_RUN: begin
				if (severe_cmp_low) begin
					state_nxt = moving ? SUV_HARD_STOP : SUV_AUTARKIC;
				end else if (warn_low_r && moving) begin
					state_nxt = SUV_SOFT_STOP;
				end else begin
					state_nxt = moving ? SUV_RUN : SUV_IDLE;
				end
			end
			SUV_SOFT_STOP: begin
				if (severe_cmp_low) begin
					state_nxt = SUV_HARD_STOP;
				end else if (motion_done) begin
					state_nxt = SUV_STOPPED_LOW;
				end
			end
			SUV_STOPPED_LOW: begin
				if (severe_cmp_low) begin
					state_nxt = SUV_AUTARKIC;
				end else if (resume_ok_r) begin
					state_nxt = SUV_RUN;
				end
			end
			SUV_HARD_STOP: state_nxt = SUV_AUTARKIC;
			SUV_AUTARKIC: begin
				if (resume_ok_r) begin
					state_nxt = SUV_RUN;
				end else if (aut_expired) begin
					state_nxt = SUV_SHUTDOWN;
				end
			end
			SUV_SHUTDOWN: begin
				if (resume_ok_r && query_hdr) begin
					state_nxt = SUV_IDLE;
				end
			end
			default: state_nxt = SUV_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= SUV_IDLE;
		end else begin
			state <= state_nxt;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || state != SUV_AUTARKIC || state_nxt != SUV_AUTARKIC) begin
			aut_cnt_r <= 32'h0;
		end else if (!aut_expired) begin
			aut_cnt_r <= aut_cnt_r + 32'h1;
		end
	end

	// ----------------------------------------
	// flags and outputs
	// ----------------------------------------
	logic clr_ok;
	assign clr_ok = query_hdr && resume_ok_r && !warn_low_r && !severe_cmp_low;
	always_ff @(posedge clk) begin
		if (rst) begin
			warn_flag <= 1'b0;
			severe_flag <= 1'b0;
			steploss_flag <= 1'b0;
		end else begin
			// setting wins over the query clear
			if (warn_low_r) begin
				warn_flag <= 1'b1;
			end else if (clr_ok) begin
				warn_flag <= 1'b0;
			end
			if (severe_cmp_low && state_nxt != state && (state_nxt == SUV_HARD_STOP
					|| state_nxt == SUV_AUTARKIC)) begin
				severe_flag <= 1'b1;
			end else if (clr_ok) begin
				severe_flag <= 1'b0;
			end
			if (state_nxt == SUV_HARD_STOP && state != SUV_HARD_STOP && !stabilizing) begin
				steploss_flag <= 1'b1;
			end else if (clr_ok) begin
				steploss_flag <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			soft_stop <= 1'b0;
			hard_stop <= 1'b0;
			bridge_hiz <= 1'b1;
			hold_current <= 1'b0;
			resume_motion <= 1'b0;
			dual_target_go <= 1'b0;
		end else begin
			soft_stop <= state_nxt == SUV_SOFT_STOP;
			hard_stop <= state_nxt == SUV_HARD_STOP;
			bridge_hiz <= state_nxt inside {SUV_HARD_STOP, SUV_AUTARKIC, SUV_SHUTDOWN};
			hold_current <= state_nxt == SUV_STOPPED_LOW;
			resume_motion <= state_nxt == SUV_RUN && state inside {SUV_STOPPED_LOW, SUV_AUTARKIC};
			dual_target_go <= dual_target_req && !severe_flag && !steploss_flag;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			target_position <= '0;
		end else if (state == SUV_AUTARKIC && aut_expired && !resume_ok_r) begin
			target_position <= actual_position;
		end else if (target_upd && state != SUV_SHUTDOWN) begin
			// flags do not block these updates, also in autarkic wait
			target_position <= target_upd_val;
		end
	end
endmodule

//--- verification/suv_lin_master.sv
// bus master model issuing status, target and store commands
`timescale 1ns/100ps
module suv_lin_master (
	input wire logic clk,
	output logic query_hdr,
	output logic target_upd,
	output logic [15:0] target_upd_val,
	output logic dual_target_req,
	output logic nvm_prog,
	output logic [3:0] nvm_addr,
	output logic [7:0] nvm_data,
	output logic nvm_rd,
	input wire logic [7:0] nvm_rdata,
	input wire logic nvm_rvalid,
	input wire logic nvm_prog_ack,
	input wire logic dual_target_go
);
	initial begin
		{query_hdr, target_upd, dual_target_req, nvm_prog, nvm_rd} = 5'h00;
		{target_upd_val, nvm_addr, nvm_data} = 28'h0000000;
	end
	task automatic pulse_q();
		@(posedge clk);
		query_hdr <= 1'b1;
		@(posedge clk);
		query_hdr <= 1'b0;
	endtask
	task automatic tgt(input logic [15:0] v);
		@(posedge clk);
		target_upd <= 1'b1;
		target_upd_val <= v;
		@(posedge clk);
		target_upd <= 1'b0;
		target_upd_val <= ~v;
	endtask
	task automatic dual(output logic go);
		@(posedge clk);
		dual_target_req <= 1'b1;
		@(posedge clk);
		dual_target_req <= 1'b0;
		go = 1'b0;
		repeat (4) begin
			@(posedge clk);
			go = go | dual_target_go;
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
		@(posedge clk);
		nvm_rd <= 1'b1;
		nvm_addr <= a;
		@(posedge clk);
		nvm_rd <= 1'b0;
		ok = 1'b0;
		for (int i = 0; i < 6 && !ok; i++) begin
			@(posedge clk);
			ok = (nvm_rvalid === 1'b1);
			d = nvm_rdata;
		end
	endtask
	// one byte per command, then read back
	task automatic prog(input logic [3:0] a, input logic [7:0] v, output logic [7:0] rb, output logic ok);
		logic ack;
		@(posedge clk);
		nvm_prog <= 1'b1;
		nvm_addr <= a;
		nvm_data <= v;
		@(posedge clk);
		nvm_prog <= 1'b0;
		nvm_data <= ~v;
		@(posedge clk);
		ack = nvm_prog_ack;
		rd(a, rb, ok);
		ok = ok & ack;
	endtask
endmodule

//--- verification/suv_supervisor_props.sv
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
module suv_supervisor_props #(
	parameter int FALL_CYC = 4,
	parameter int RISE_CYC = 6,
	parameter int AUT_CYC = 50,
	parameter int POS_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic warn_cmp_low,
	input wire logic severe_cmp_low,
	input wire logic resume_cmp_high,
	input wire logic moving,
	input wire logic stabilizing,
	input wire logic [POS_W-1:0] actual_position,
	input wire logic query_hdr,
	input wire logic dual_target_req,
	input wire logic nvm_rd,
	input wire logic nvm_rvalid,
	input wire logic warn_flag,
	input wire logic severe_flag,
	input wire logic steploss_flag,
	input wire logic hard_stop,
	input wire logic bridge_hiz,
	input wire logic hold_current,
	input wire logic resume_motion,
	input wire logic dual_target_go,
	input wire logic [POS_W-1:0] target_position,
	input wire suv_pkg::suv_state_t state
);
	import suv_pkg::*;
	int warn_run_r;
	int rise_run_r;
	int aut_cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ----
	// run lengths, too long for a repetition
	// ----
	always_ff @(posedge clk) begin
		warn_run_r <= (!rst && warn_cmp_low) ? warn_run_r + 1 : 0;
		rise_run_r <= (!rst && resume_cmp_high) ? rise_run_r + 1 : 0;
	end
	always_ff @(posedge clk) begin
		aut_cnt_r <= (!rst && state == SUV_AUTARKIC) ? aut_cnt_r + 1 : 0;
	end
	// ----
	// properties
	// ----
	sequence s_aut_hiz;
		state == SUV_AUTARKIC && bridge_hiz;
	endsequence
	sequence s_shut_entry;
		state == SUV_SHUTDOWN && $past(state) == SUV_AUTARKIC;
	endsequence
	a_warn_clear: assert property ($fell(warn_flag) |-> $past(query_hdr) && $past(resume_cmp_high))
		else $error("warn flag cleared without query");
	a_warn_deb: assert property ($rose(warn_flag) && !$past(severe_cmp_low) |-> warn_run_r >= FALL_CYC)
		else $error("warn flag before debounce");
	a_rise_deb: assert property ($rose(resume_motion) |-> rise_run_r >= RISE_CYC)
		else $error("resume before debounce");
	a_steploss_cause: assert property ($rose(steploss_flag) |-> $past(moving) && !$past(stabilizing))
		else $error("step loss flag without moving hard stop");
	a_hard_hiz: assert property ($rose(hard_stop) |-> ##[0:3] s_aut_hiz)
		else $error("hard stop not followed by autarkic high impedance");
	a_low_hold: assert property (state == SUV_STOPPED_LOW |-> hold_current && !steploss_flag)
		else $error("stopped low without hold current");
	a_dual_gate: assert property (dual_target_go |-> $past(dual_target_req) && !$past(severe_flag | steploss_flag))
		else $error("dual target taken with flags set");
	a_shut_target: assert property (s_shut_entry |-> ##[0:1] target_position == actual_position)
		else $error("shutdown target not actual position");
	a_aut_timer: assert property (s_shut_entry |-> aut_cnt_r >= AUT_CYC - 2 && aut_cnt_r <= AUT_CYC + 2)
		else $error("autarkic wait length wrong");
	a_shut_exit: assert property ($past(state) == SUV_SHUTDOWN && state != SUV_SHUTDOWN
		|-> $past(query_hdr) && $past(resume_cmp_high))
		else $error("shutdown left without query above resume");
	a_read_lat: assert property (nvm_rvalid |-> $past(nvm_rd, 3))
		else $error("read answer latency wrong");
endmodule
bind suv_supervisor suv_supervisor_props #(.FALL_CYC(FALL_CYC), .RISE_CYC(RISE_CYC), .AUT_CYC(AUT_CYC),
	.POS_W(POS_W)) props_u (.clk, .rst, .warn_cmp_low, .severe_cmp_low, .resume_cmp_high, .moving,
	.stabilizing, .actual_position, .query_hdr, .dual_target_req, .nvm_rd, .nvm_rvalid, .warn_flag,
	.severe_flag, .steploss_flag, .hard_stop, .bridge_hiz, .hold_current, .resume_motion, .dual_target_go,
	.target_position, .state);

//--- verification/suv_supervisor_tb.sv
// self-checking bench for the supply supervisor
`timescale 1ns/100ps
module suv_supervisor_tb;
	import suv_pkg::*;
	localparam int FC = 4;
	localparam int RLC = 10;
	localparam int AC = 50;
	logic clk = 0;
	logic rst = 1;
	logic warn_cmp_low = 0, severe_cmp_low = 0, resume_cmp_high = 1, moving = 0, stabilizing = 0, motion_done = 0;
	logic [15:0] act = 16'h0abc;
	logic query_hdr, target_upd, dual_target_req, nvm_prog, nvm_rd, nvm_rvalid, nvm_prog_ack;
	logic [15:0] target_upd_val, target_position;
	logic [3:0] nvm_addr;
	logic [7:0] nvm_data, nvm_rdata;
	logic warn_flag, severe_flag, steploss_flag, soft_stop, hard_stop, bridge_hiz, hold_current;
	logic resume_motion, dual_target_go, failsafe_en, sleep_allow;
	logic [2:0] warn_level_select;
	logic [10:0] secure_position;
	suv_state_t state;
	int n_errors = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	suv_supervisor #(.FALL_CYC(FC), .RISE_CYC(6), .RISE_LONG_CYC(RLC), .AUT_CYC(AC)) dut_u (.clk, .rst,
		.warn_cmp_low, .severe_cmp_low, .resume_cmp_high, .moving, .stabilizing, .motion_done,
		.actual_position(act), .query_hdr, .target_upd, .target_upd_val, .dual_target_req, .nvm_prog,
		.nvm_addr, .nvm_data, .nvm_rd, .nvm_rdata, .nvm_rvalid, .nvm_prog_ack, .warn_flag, .severe_flag,
		.steploss_flag, .soft_stop, .hard_stop, .bridge_hiz, .hold_current, .resume_motion, .dual_target_go,
		.target_position, .warn_level_select, .secure_position, .failsafe_en, .sleep_allow, .state);
	suv_lin_master m_u (.clk, .query_hdr, .target_upd, .target_upd_val, .dual_target_req, .nvm_prog,
		.nvm_addr, .nvm_data, .nvm_rd, .nvm_rdata, .nvm_rvalid, .nvm_prog_ack, .dual_target_go);
	// ----
	// shared tasks
	// ----
	task automatic chk_b(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t flag %b exp %b", $time, g, e);
		end
	endtask
	task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t value %h exp %h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tmo();
		n_errors++;
		$display("ERROR %0t wait timed out", $time);
		stop_test();
	endtask
	task automatic wait_st(input suv_state_t s, input int lim);
		for (int i = 0; i <= lim; i++) begin
			@(posedge clk);
			if (state === s) return;
		end
		tmo();
	endtask
	task automatic wait_rm(input int lim);
		for (int i = 0; i <= lim; i++) begin
			@(posedge clk);
			if (resume_motion === 1'b1) return;
		end
		tmo();
	endtask
	// store loads only after release, so wait out the load walk
	task automatic do_reset();
		rst <= 1'b1;
		{warn_cmp_low, severe_cmp_low, resume_cmp_high, moving, stabilizing} <= 5'b00100;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (14) @(posedge clk);
	endtask
	task automatic pr(input logic [3:0] a, input logic [7:0] v, input logic [7:0] e);
		logic [7:0] d;
		logic ok;
		m_u.prog(a, v, d, ok);
		chk_b(ok, 1'b1);
		chk_v({8'h00, d}, {8'h00, e});
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_warn();
		do_reset();
		moving <= 1'b1;
		m_u.tgt(16'h1234);
		{warn_cmp_low, resume_cmp_high} <= 2'b10;
		repeat (FC - 1) @(posedge clk);
		warn_cmp_low <= 1'b0;
		repeat (4) @(posedge clk);
		chk_b(warn_flag, 1'b0);
		warn_cmp_low <= 1'b1;
		repeat (FC + 3) @(posedge clk);
		chk_b(warn_flag & soft_stop, 1'b1);
		motion_done <= 1'b1;
		@(posedge clk);
		{motion_done, moving} <= 2'b00;
		wait_st(SUV_STOPPED_LOW, 8);
		chk_b(hold_current & !steploss_flag, 1'b1);
		chk_v(target_position, 16'h1234);
		m_u.pulse_q();
		repeat (2) @(posedge clk);
		chk_b(warn_flag, 1'b1);
		{warn_cmp_low, resume_cmp_high} <= 2'b01;
		wait_rm(RLC + 8);
		m_u.pulse_q();
		repeat (2) @(posedge clk);
		chk_b(warn_flag, 1'b0);
		$display("done warn");
	endtask
	task automatic t_hard();
		logic go;
		do_reset();
		moving <= 1'b1;
		{warn_cmp_low, severe_cmp_low, resume_cmp_high} <= 3'b110;
		wait_st(SUV_AUTARKIC, 8);
		chk_b(bridge_hiz & severe_flag & steploss_flag, 1'b1);
		m_u.tgt(16'h0555);
		@(posedge clk);
		chk_v(target_position, 16'h0555);
		m_u.dual(go);
		chk_b(go, 1'b0);
		wait_st(SUV_SHUTDOWN, AC + 10);
		@(posedge clk);
		chk_v(target_position, act);
		{warn_cmp_low, severe_cmp_low, moving} <= 3'b000;
		m_u.pulse_q();
		repeat (RLC + 4) @(posedge clk);
		chk_b(state == SUV_SHUTDOWN, 1'b1);
		resume_cmp_high <= 1'b1;
		repeat (RLC + 4) @(posedge clk);
		chk_b(state == SUV_SHUTDOWN, 1'b1);
		m_u.pulse_q();
		repeat (2) @(posedge clk);
		chk_b(state == SUV_SHUTDOWN, 1'b0);
		chk_b(severe_flag, 1'b0);
		$display("done hard stop");
	endtask
	task automatic t_stab();
		logic go;
		do_reset();
		{moving, stabilizing} <= 2'b11;
		{warn_cmp_low, severe_cmp_low, resume_cmp_high} <= 3'b110;
		wait_st(SUV_AUTARKIC, 8);
		chk_b(severe_flag & !steploss_flag, 1'b1);
		{warn_cmp_low, severe_cmp_low, resume_cmp_high, stabilizing} <= 4'b0010;
		wait_rm(RLC + 8);
		m_u.pulse_q();
		repeat (2) @(posedge clk);
		m_u.dual(go);
		chk_b(go, 1'b1);
		$display("done stabilization");
	endtask
	task automatic t_stop();
		do_reset();
		{warn_cmp_low, severe_cmp_low, resume_cmp_high} <= 3'b110;
		wait_st(SUV_AUTARKIC, 8);
		chk_b(severe_flag & !steploss_flag, 1'b1);
		$display("done stopped drop");
	endtask
	task automatic t_store();
		logic [7:0] d;
		logic ok;
		do_reset();
		pr(4'h3, 8'h0f, 8'h0f);
		pr(4'h3, 8'hf0, 8'hff);
		pr(4'h7, 8'hb2, 8'hb2);
		pr(4'h0, 8'hff, 8'h80);
		pr(4'h1, 8'hff, 8'hc0);
		pr(4'h8, 8'hff, 8'he0);
		pr(4'h9, 8'h07, 8'h07);
		chk_v({13'h0000, warn_level_select}, 16'h0000);
		do_reset();
		chk_v({13'h0000, warn_level_select}, 16'h0003);
		chk_v({5'h00, secure_position}, 16'h0704);
		chk_b(failsafe_en & sleep_allow, 1'b1);
		m_u.rd(4'h5, d, ok);
		chk_v({7'h00, ok, d}, 16'h01e0);
		pr(4'h7, 8'h01, 8'hb3);
		pr(4'h4, 8'h55, 8'h00);
		$display("done store");
	endtask
	initial begin
		t_warn();
		t_hard();
		t_stab();
		t_stop();
		t_store();
		stop_test();
	end
endmodule
